// ---- rtl/hcr_pkg.sv ----
// constants for the host control, topology and channel filter registers
package hcr_pkg;
    // register byte offsets
    localparam logic [7:0] HCR_CTRL_SET_OFS = 8'h50;
    localparam logic [7:0] HCR_CTRL_CLR_OFS = 8'h54;
    localparam logic [7:0] HCR_TOPO_BASE_OFS = 8'h64;
    localparam logic [7:0] HCR_TOPO_CNT_OFS = 8'h68;
    localparam logic [7:0] HCR_CHAN_SET_OFS = 8'h70;
    localparam logic [7:0] HCR_CHAN_CLR_OFS = 8'h74;
    // control register field positions
    localparam int HCR_LINK_EN_BIT = 17;
    localparam int HCR_SELF_RST_BIT = 16;
    localparam int HCR_BUF_WR_EN_BIT = 18;
    // topology base field
    localparam int HCR_BASE_LSB = 11;
    // topology count/status field positions
    localparam int HCR_FAULT_BIT = 31;
    localparam int HCR_EPOCH_LSB = 16;
    localparam int HCR_QCNT_LSB = 2;
    localparam int HCR_QCNT_W = 9;
    // reset values
    localparam logic [31:0] HCR_CHAN_RST = 32'h0000_0000;
    localparam logic [20:0] HCR_BASE_RST = 21'h00_0000;
    localparam logic [7:0] HCR_EPOCH_RST = 8'h00;
    // self reset duration in cycles
    localparam int HCR_SELF_RST_CYC = 16;
endpackage

// ---- rtl/hcr_regs.sv ----
// host control, topology buffer and upper channel filter register bank
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
// Operation
// [R1] link enable cleared by hardware reset or self reset
// [R2] software sets link enable when ready, then forces a bus reset
// [R3] link enable low means disconnected: no receive, process or transmit
// [R4] self reset clears internal state, flushes fifos, restores registers
// [R5] self reset leaves host bus configuration registers untouched
// [R6] self reset bit reads one while in progress, clears itself
// [R7] control bits 15..0 always read as zero
// [R8] only base bits 31..11 writable and readable, 2 KB aligned
// [R9] self-ID packets stored from the programmed base address
// [R10] fault bit set when latest self-ID reception saw an error
// [R11] hardware errors and host bus write failures count as faults
// [R12] fault bit cleared after an error free self-ID reception
// [R13] epoch counts every bus reset, wraps 255 to zero; code counts bus resets only while link enable is set and no self reset runs
// [R14] quadlet count cleared at the start of each reception
// [R15] quadlet count tracks header plus data quadlets written
// [R16] count register reserved bits read as zero
// [R17] filter bit n enables isochronous channel n plus 32
// [R18] reading set or clear offset returns current filter
// [R19] software changes buffered write enable only with link disabled
// [R20] one at set offset sets, one at clear offset clears
// [R21] link enable held clear during self reset
module hcr_regs #(
    parameter int SELF_RST_CYC = hcr_pkg::HCR_SELF_RST_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // link receive side events
    input wire logic i_bus_reset,
    input wire logic i_rx_start,
    input wire logic i_rx_quadlet,
    input wire logic i_rx_done,
    input wire logic i_rx_hw_err,
    input wire logic i_rx_wr_fail,
    // state toward the link core
    output logic o_link_operation_enable,
    output logic o_controller_self_reset,
    output logic o_buffered_write_enable,
    output logic [31:0] o_topology_packet_buffer_base,
    output logic [31:0] o_upper_channel_filter
);

    localparam logic [4:0] RST_LAST = 5'(SELF_RST_CYC - 1);

    typedef enum logic [1:0] {
        HCR_RUN = 2'b01,
        HCR_SRST = 2'b10
    } hcr_state_t;

    hcr_state_t state_q;
    logic [4:0] rst_cnt_q;
    logic link_en_q;
    logic buf_wr_en_q;
    logic [20:0] base_q;
    logic fault_q;
    logic err_seen_q;
    logic [7:0] epoch_q;
    logic [8:0] qcnt_q;
    logic [31:0] chan_q;
    logic [31:0] rdata_q;
    logic srst;
    logic wr_ctrl_set;
    logic wr_ctrl_clr;
    logic rx_live;

    // decode of writes, self reset in progress flag
    assign wr_ctrl_set = i_wr && (i_addr == hcr_pkg::HCR_CTRL_SET_OFS);
    assign wr_ctrl_clr = i_wr && (i_addr == hcr_pkg::HCR_CTRL_CLR_OFS);
    assign srst = (state_q == HCR_SRST); // [R6]
    // receive events only count while connected and not resetting
    assign rx_live = link_en_q && !srst; // [R3]

    // self reset sequencer; counts a fixed number of cycles then ends
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_q <= HCR_RUN;
            rst_cnt_q <= 5'h00;
        end else begin
            unique case (state_q)
                HCR_RUN: begin
                    if (wr_ctrl_set && i_wdata[hcr_pkg::HCR_SELF_RST_BIT]) begin
                        state_q <= HCR_SRST; // [R4]
                        rst_cnt_q <= 5'h00;
                    end
                end
                HCR_SRST: begin
                    if (rst_cnt_q == RST_LAST) begin
                        state_q <= HCR_RUN; // [R6]
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= HCR_RUN;
                end
            endcase
        end
    end

    // link enable; set requests ignored while a self reset runs
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            link_en_q <= 1'b0; // [R1]
        end else if (srst) begin
            link_en_q <= 1'b0; // [R1] [R21]
        end else if (wr_ctrl_set && i_wdata[hcr_pkg::HCR_SELF_RST_BIT]) begin
            link_en_q <= 1'b0; // [R1]
        end else if (wr_ctrl_set && i_wdata[hcr_pkg::HCR_LINK_EN_BIT]) begin
            link_en_q <= 1'b1; // [R20]
        end else if (wr_ctrl_clr && i_wdata[hcr_pkg::HCR_LINK_EN_BIT]) begin
            link_en_q <= 1'b0; // [R20]
        end
    end

    // buffered write enable; software keeps it stable while linked
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            buf_wr_en_q <= 1'b0; // [R4]
        end else if (wr_ctrl_set && i_wdata[hcr_pkg::HCR_BUF_WR_EN_BIT]) begin
            buf_wr_en_q <= 1'b1; // [R20]
        end else if (wr_ctrl_clr && i_wdata[hcr_pkg::HCR_BUF_WR_EN_BIT]) begin
            buf_wr_en_q <= 1'b0; // [R20]
        end
    end

    // topology buffer base, only the aligned upper bits are stored
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            base_q <= hcr_pkg::HCR_BASE_RST; // [R4]
        end else if (i_wr && i_addr == hcr_pkg::HCR_TOPO_BASE_OFS) begin
            base_q <= i_wdata[31:hcr_pkg::HCR_BASE_LSB]; // [R8]
        end
    end

    // bus reset epoch, wraps naturally at eight bits
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            epoch_q <= hcr_pkg::HCR_EPOCH_RST; // [R4]
        end else if (rx_live && i_bus_reset) begin
            epoch_q <= epoch_q + 8'h01; // [R13]
        end
    end

    // quadlet count; start wins over a same cycle quadlet
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            qcnt_q <= 9'h000;
        end else if (rx_live && i_rx_start) begin
            qcnt_q <= 9'h000; // [R14]
        end else if (rx_live && i_rx_quadlet && qcnt_q != 9'h1FF) begin
            qcnt_q <= qcnt_q + 9'h001; // [R15] [R9]
        end
    end

    // error gathered over one reception, judged at its end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            err_seen_q <= 1'b0;
        end else if (rx_live && i_rx_start) begin
            err_seen_q <= i_rx_hw_err || i_rx_wr_fail; // [R11]
        end else if (rx_live && (i_rx_hw_err || i_rx_wr_fail)) begin
            err_seen_q <= 1'b1; // [R11]
        end
    end

    // fault flag; an error in the last cycle still counts
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            fault_q <= 1'b0;
        end else if (rx_live && i_rx_done) begin
            fault_q <= err_seen_q || i_rx_hw_err || i_rx_wr_fail; // [R10] [R12]
        end
    end

    // upper channel filter, set wins if both offsets hit at once
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || srst) begin
            chan_q <= hcr_pkg::HCR_CHAN_RST; // [R4]
        end else if (i_wr && i_addr == hcr_pkg::HCR_CHAN_SET_OFS) begin
            chan_q <= chan_q | i_wdata; // [R20] [R17]
        end else if (i_wr && i_addr == hcr_pkg::HCR_CHAN_CLR_OFS) begin
            chan_q <= chan_q & ~i_wdata; // [R20]
        end
    end

    // read mux; unmapped offsets and reserved bits read zero
    // not cleared by self reset: bus side state stays put
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            rdata_q <= 32'h0000_0000; // [R5]
        end else if (i_rd) begin
            unique case (i_addr)
                hcr_pkg::HCR_CTRL_SET_OFS,
                hcr_pkg::HCR_CTRL_CLR_OFS: begin
                    rdata_q <= {13'h0000, buf_wr_en_q, link_en_q, srst,
                                16'h0000}; // [R7] [R6]
                end
                hcr_pkg::HCR_TOPO_BASE_OFS: begin
                    rdata_q <= {base_q, 11'h000}; // [R8]
                end
                hcr_pkg::HCR_TOPO_CNT_OFS: begin
                    rdata_q <= {fault_q, 7'h00, epoch_q, 5'h00, qcnt_q,
                                2'h0}; // [R16]
                end
                hcr_pkg::HCR_CHAN_SET_OFS,
                hcr_pkg::HCR_CHAN_CLR_OFS: begin
                    rdata_q <= chan_q; // [R18]
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // outputs toward the link core, registered
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_link_operation_enable <= 1'b0;
            o_controller_self_reset <= 1'b0;
            o_buffered_write_enable <= 1'b0;
            o_topology_packet_buffer_base <= 32'h0000_0000;
            o_upper_channel_filter <= 32'h0000_0000;
        end else begin
            o_link_operation_enable <= link_en_q && !srst; // [R3]
            o_controller_self_reset <= srst; // [R4]
            o_buffered_write_enable <= buf_wr_en_q;
            o_topology_packet_buffer_base <= {base_q, 11'h000}; // [R9]
            o_upper_channel_filter <= chan_q; // [R17]
        end
    end

    assign o_rdata = rdata_q;

endmodule // hcr_regs

// ---- verification/hcr_regs_assertions.sv ----
// port checks for the host control register bank
`timescale 1ns/10ps
module hcr_regs_assertions #(
    parameter int SELF_RST_CYC = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_link_operation_enable,
    input wire logic o_controller_self_reset,
    input wire logic [31:0] o_topology_packet_buffer_base,
    input wire logic [31:0] o_upper_channel_filter
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0] ra_q;
    int sr_cnt_q;
    logic sr_req;
    // address of the read answered now, ff when none
    always_ff @(posedge i_mclk) ra_q <= i_rd ? i_addr : 8'hFF;
    // length of the self reset as seen at the port
    always_ff @(posedge i_mclk) begin
        sr_cnt_q <= (i_rst_b && o_controller_self_reset) ? sr_cnt_q + 1 : 0;
    end
    assign sr_req = i_wr && i_addr == 8'h50 && i_wdata[16];
    ctrl_read_a: assert property (ra_q == 8'h50 || ra_q == 8'h54 |->
        o_rdata[15:0] == 16'h0 && o_rdata[17] == o_link_operation_enable)
        else $error("control read wrong");
    count_rsvd_a: assert property (ra_q == 8'h68 |->
        o_rdata[30:24] == 7'h0 && o_rdata[15:11] == 5'h0
        && o_rdata[1:0] == 2'h0)
        else $error("count reserved bits set");
    base_read_a: assert property (ra_q == 8'h64 |->
        o_rdata == o_topology_packet_buffer_base) else $error("base read");
    base_align_a: assert property (
        o_topology_packet_buffer_base[10:0] == 11'h0) else $error("base low");
    filter_read_a: assert property (ra_q == 8'h70 || ra_q == 8'h74 |->
        o_rdata == o_upper_channel_filter) else $error("filter read");
    filter_set_a: assert property (i_wr && i_addr == 8'h70 ##1 !i_wr |=>
        (o_upper_channel_filter & $past(i_wdata, 2)) == $past(i_wdata, 2))
        else $error("filter set lost");
    filter_clr_a: assert property (i_wr && i_addr == 8'h74 ##1 !i_wr |=>
        (o_upper_channel_filter & $past(i_wdata, 2)) == 32'h0)
        else $error("filter clear lost");
    link_hold_a: assert property (o_controller_self_reset |->
        !o_link_operation_enable) else $error("link on in self reset");
    hw_reset_a: assert property (!$past(i_rst_b) |->
        !o_link_operation_enable && !o_controller_self_reset)
        else $error("outputs set after reset");
    sr_start_a: assert property ($rose(o_controller_self_reset) |->
        $past(sr_req, 2)) else $error("self reset uncaused");
    sr_len_a: assert property ($fell(o_controller_self_reset) |->
        sr_cnt_q == SELF_RST_CYC) else $error("self reset length");
    cover property ($fell(o_controller_self_reset));
    cover property (ra_q == 8'h68);
    cover property (o_upper_channel_filter[31]);
endmodule // hcr_regs_assertions

// ---- verification/hcr_link_model.sv ----
// link receive side model: bus resets and self-ID reception events
`timescale 1ns/10ps
module hcr_link_model (
    input wire logic i_mclk,
    output logic [5:0] o_ev
);
    // bits: bus reset, start, quadlet, done, hw error, write fail
    logic [5:0] ev_q = 6'h00;
    assign o_ev = ev_q;
    // single cycle pulse; lines idle low between events
    task automatic pulse(input logic [5:0] ev);
        @(posedge i_mclk);
        ev_q <= ev;
        @(posedge i_mclk);
        ev_q <= 6'h00;
    endtask
    // bus reset first, then header plus data quadlets
    task automatic selfid(input int n, input logic [5:0] err);
        pulse(6'h20);
        pulse(6'h10);
        repeat (n) pulse(6'h08);
        if (err != 6'h00) pulse(err);
        pulse(6'h04);
    endtask
endmodule // hcr_link_model

// ---- verification/tb.sv ----
// self-checking bench for the host control register bank
`timescale 1ns/10ps
module tb;
    logic i_mclk, i_rst_b, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [5:0] ev;
    logic o_link, o_buf;
    int fails = 0;
    int n_tests = 0;
    typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra;
        logic [31:0] ex;} hcr_row_t;
    // write, then read back; row six enables the link, the last row clears buffered write
    hcr_row_t rows [7] = '{'{8'h64, 32'hFFFF_FFFF, 8'h64, 32'hFFFF_F800},
        '{8'h70, 32'h8000_0001, 8'h74, 32'h8000_0001},
        '{8'h74, 32'h0000_0001, 8'h70, 32'h8000_0000},
        '{8'h68, 32'hFFFF_FFFF, 8'h68, 32'h0000_0000},
        '{8'h3C, 32'hFFFF_FFFF, 8'h3C, 32'h0000_0000},
        '{8'h50, 32'h0006_FFFF, 8'h54, 32'h0006_0000},
        '{8'h54, 32'h0004_0000, 8'h50, 32'h0002_0000}};
    // quadlets, error kind, expected count register
    hcr_row_t sid [4] = '{'{8'h03, 32'h00, 8'h0, 32'h0001_000C},
        '{8'h02, 32'h02, 8'h0, 32'h8002_0008},
        '{8'h01, 32'h01, 8'h0, 32'h8003_0004},
        '{8'h04, 32'h00, 8'h0, 32'h0004_0010}};
    logic [7:0] zr [4] = '{8'h50, 8'h68, 8'h64, 8'h70};
    // short self reset keeps the run brief
    hcr_regs #(.SELF_RST_CYC(8)) u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_bus_reset(ev[5]), .i_rx_start(ev[4]),
        .i_rx_quadlet(ev[3]), .i_rx_done(ev[2]), .i_rx_hw_err(ev[1]),
        .i_rx_wr_fail(ev[0]), .o_link_operation_enable(o_link),
        .o_controller_self_reset(), .o_buffered_write_enable(o_buf),
        .o_topology_packet_buffer_base(), .o_upper_channel_filter());
    hcr_link_model u_link (.i_mclk(i_mclk), .o_ev(ev));
    task automatic conclude();
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] ex);
        n_tests++;
        if (got !== ex) begin
            $display("mismatch at %0t got %h exp %h", $time, got, ex);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // answer stands one cycle only, so sample mid cycle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        cmp(o_rdata, ex);
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        fails++;
        conclude();
    end
    initial begin
        {i_rst_b, i_wr, i_rd, i_addr, i_wdata} = 43'h0;
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd_chk(rows[i].ra, rows[i].ex);
        end
        cmp({30'h0, o_buf, o_link}, 32'h1);
        // link is on, so every bus reset and reception counts
        foreach (sid[i]) begin
            u_link.selfid(sid[i].wa, sid[i].wd[5:0]);
            repeat (2) @(posedge i_mclk);
            rd_chk(8'h68, sid[i].ex);
        end
        repeat (252) u_link.pulse(6'h20);
        rd_chk(8'h68, 32'h0000_0010);
        // link off: a faulty reception must leave the count alone
        wr(8'h54, 32'h0002_0000);
        u_link.selfid(2, 6'h02);
        rd_chk(8'h68, 32'h0000_0010);
        cmp({31'h0, o_link}, 32'h0);
        // link set in the same write as self reset is refused
        wr(8'h50, 32'h0003_0000);
        rd_chk(8'h50, 32'h0001_0000);
        cmp({31'h0, o_link}, 32'h0);
        repeat (12) @(posedge i_mclk);
        foreach (zr[i]) rd_chk(zr[i], 32'h0);
        wr(8'h50, 32'h0002_0000);
        rd_chk(8'h50, 32'h0002_0000);
        cmp({31'h0, o_link}, 32'h1);
        wr(8'h70, 32'h0000_0001);
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        rd_chk(8'h50, 32'h0);
        rd_chk(8'h70, 32'h0);
        cmp({30'h0, o_buf, o_link}, 32'h0);
        conclude();
    end
endmodule // tb
bind hcr_regs hcr_regs_assertions #(.SELF_RST_CYC(SELF_RST_CYC)) u_chk (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_link_operation_enable(o_link_operation_enable),
    .o_controller_self_reset(o_controller_self_reset),
    .o_topology_packet_buffer_base(o_topology_packet_buffer_base),
    .o_upper_channel_filter(o_upper_channel_filter));
